// File: core/pfi_host.sv
// Host controller that drives a four-plane asynchronous flash through its pins.
//
// Contract
// - Host keeps the reset pin low during power-up and power-down.
// - Address and data latch on first rising edge; host holds them valid.
// - One erase or program at a time; host never starts a second.
// - Host gives every command an address inside its target block.
// - Host never asserts output gate and write strobe together.
`timescale 1ns/100ps
module pfi_host (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic req_i,
	input pfi_pkg::pfi_req_t req_data_i,
	input wire logic protect_i,
	input wire logic [pfi_pkg::DATA_W-1:0] data_lines_i,
	input wire logic ready_busy_n_i,
	output logic ready_o,
	output logic ack_o,
	output logic refused_o,
	output logic [pfi_pkg::DATA_W-1:0] rdata_o,
	output logic op_pending_o,
	output pfi_pkg::pfi_pins_t pins_o
);
	import pfi_pkg::*;

	// ==========================================================================
	// State
	// ==========================================================================
	typedef struct packed {
		pfi_state_t st;
		logic [7:0] cnt;
		pfi_pins_t pins;
		logic ack;
		logic refused;
		logic [DATA_W-1:0] rdata;
		logic [7:0] last_cmd;
		logic [BLK_W-1:0] last_blk;
		logic pend;
		logic seen_busy;
		logic rdy;
	} pfi_host_t;

	pfi_host_t s_reg;
	pfi_host_t s_next;
	pfi_blk_t req_blk;

	pfi_block_map u_map (
		.addr_i(req_data_i.addr),
		.blk_o(req_blk)
	);

	// ==========================================================================
	// Command classes
	// ==========================================================================
	// Commands whose second write must follow at an address in the same block.
	function automatic logic is_pair(input logic [7:0] c);
		return (c == CMD_BLOCK_ERASE) || (c == CMD_CHIP_ERASE) || (c == CMD_PROGRAM_A) ||
			(c == CMD_PROGRAM_B) || (c == CMD_OTP_PROGRAM) || (c == CMD_LOCK_SETUP);
	endfunction : is_pair

	// Commands that set the write state machine running once confirmed.
	function automatic logic is_start(input logic [7:0] c);
		return (c == CMD_BLOCK_ERASE) || (c == CMD_CHIP_ERASE) || (c == CMD_PROGRAM_A) ||
			(c == CMD_PROGRAM_B) || (c == CMD_OTP_PROGRAM) || (c == CMD_PAGE_PROGRAM);
	endfunction : is_start

	// ==========================================================================
	// Next state
	// ==========================================================================
	always_comb begin
		logic second;
		logic bad_blk;
		logic busy_now;
		second = 1'b0;
		bad_blk = 1'b0;
		busy_now = 1'b0;
		s_next = s_reg;
		s_next.ack = 1'b0;
		s_next.refused = 1'b0;
		s_next.pins.protect_accel_pin = protect_i;

		// An operation this host started counts as running until the device
		// has been seen busy and then ready again.
		if (s_reg.pend && !ready_busy_n_i) begin
			s_next.seen_busy = 1'b1;
		end
		if (s_reg.pend && s_reg.seen_busy && ready_busy_n_i) begin
			s_next.pend = 1'b0;
			s_next.seen_busy = 1'b0;
		end

		case (s_reg.st)
			ST_RST_LOW: begin
				s_next.pins.rst_n = 1'b0;
				if (s_reg.cnt == '0) begin
					s_next.pins.rst_n = 1'b1;
					s_next.cnt = RST_RECOV_CYC - 8'h01;
					s_next.st = ST_RST_RECOV;
				end else begin
					s_next.cnt = s_reg.cnt - 8'h01;
				end
			end
			ST_RST_RECOV: begin
				if (s_reg.cnt == '0) begin
					s_next.last_cmd = CMD_READ_ARRAY;
					s_next.st = ST_IDLE;
				end else begin
					s_next.cnt = s_reg.cnt - 8'h01;
				end
			end
			ST_IDLE: begin
				if (req_i) begin
					second = is_pair(s_reg.last_cmd);
					bad_blk = second && (req_blk.block != s_reg.last_blk);
					busy_now = s_reg.pend || !ready_busy_n_i;
					if (req_data_i.wr && (bad_blk ||
						(!second && is_start(req_data_i.wdata[7:0]) && busy_now))) begin
						s_next.ack = 1'b1;
						s_next.refused = 1'b1;
					end else begin
						s_next.pins.ce_n = 1'b0;
						s_next.pins.word_address_lines = req_data_i.addr;
						if (req_data_i.wr) begin
							s_next.pins.data_lines_out = req_data_i.wdata;
							s_next.pins.data_lines_oe = 1'b1;
							s_next.cnt = WE_SETUP_CYC - 8'h01;
							s_next.st = ST_W_SETUP;
							if (second) begin
								s_next.last_cmd = CMD_READ_ARRAY;
								// A confirm that starts nothing must not drop a running operation.
								if (is_start(s_reg.last_cmd)) begin
									s_next.pend = 1'b1;
									s_next.seen_busy = 1'b0;
								end
							end else begin
								s_next.last_cmd = req_data_i.wdata[7:0];
								s_next.last_blk = req_blk.block;
							end
						end else begin
							s_next.pins.oe_n = 1'b0;
							s_next.cnt = READ_ACC_CYC - 8'h01;
							s_next.st = ST_R_ACCESS;
						end
					end
				end
			end
			ST_W_SETUP: begin
				if (s_reg.cnt == '0) begin
					s_next.pins.we_n = 1'b0;
					s_next.cnt = WE_PULSE_CYC - 8'h01;
					s_next.st = ST_W_PULSE;
				end else begin
					s_next.cnt = s_reg.cnt - 8'h01;
				end
			end
			ST_W_PULSE: begin
				if (s_reg.cnt == '0) begin
					s_next.pins.we_n = 1'b1;
					s_next.cnt = WE_HOLD_CYC - 8'h01;
					s_next.st = ST_W_HOLD;
				end else begin
					s_next.cnt = s_reg.cnt - 8'h01;
				end
			end
			ST_W_HOLD: begin
				// Address and data stay put until after the strobe has risen.
				if (s_reg.cnt == '0) begin
					s_next.pins.ce_n = 1'b1;
					s_next.pins.data_lines_oe = 1'b0;
					s_next.ack = 1'b1;
					s_next.st = ST_IDLE;
				end else begin
					s_next.cnt = s_reg.cnt - 8'h01;
				end
			end
			ST_R_ACCESS: begin
				if (s_reg.cnt == '0) begin
					s_next.rdata = data_lines_i;
					s_next.pins.oe_n = 1'b1;
					s_next.pins.ce_n = 1'b1;
					s_next.ack = 1'b1;
					s_next.st = ST_IDLE;
				end else begin
					s_next.cnt = s_reg.cnt - 8'h01;
				end
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase
		s_next.rdy = (s_next.st == ST_IDLE);
	end

	// ==========================================================================
	// Registers
	// ==========================================================================
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_reg.st <= ST_RST_LOW;
			s_reg.cnt <= RST_PULSE_CYC - 8'h01;
			s_reg.pins.ce_n <= 1'b1;
			s_reg.pins.oe_n <= 1'b1;
			s_reg.pins.we_n <= 1'b1;
			s_reg.pins.rst_n <= 1'b0;
			s_reg.pins.protect_accel_pin <= 1'b0;
			s_reg.pins.word_address_lines <= '0;
			s_reg.pins.data_lines_out <= '0;
			s_reg.pins.data_lines_oe <= 1'b0;
			s_reg.ack <= 1'b0;
			s_reg.refused <= 1'b0;
			s_reg.rdata <= '0;
			s_reg.last_cmd <= CMD_READ_ARRAY;
			s_reg.last_blk <= '0;
			s_reg.pend <= 1'b0;
			s_reg.seen_busy <= 1'b0;
			s_reg.rdy <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	assign pins_o = s_reg.pins;
	assign ack_o = s_reg.ack;
	assign refused_o = s_reg.refused;
	assign rdata_o = s_reg.rdata;
	assign op_pending_o = s_reg.pend;
	assign ready_o = s_reg.rdy;
endmodule : pfi_host

// File: core/pfi_pkg.sv
// Shared constants, states and carrier types of the flash host controller.
package pfi_pkg;
	// ==========================================================================
	// Geometry
	// ==========================================================================
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int BLK_W = 7;
	localparam int PARAM_LSB = 12;
	localparam int MAIN_LSB = 15;
	localparam int PLANE_LSB = 19;
	localparam logic [BLK_W-1:0] PARAM_BLOCKS = 7'h08;
	localparam logic [BLK_W-1:0] MAIN_BASE_BLK = 7'h07;

	// ==========================================================================
	// Command codes
	// ==========================================================================
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
	localparam logic [7:0] CMD_PROGRAM_A = 8'h40;
	localparam logic [7:0] CMD_PROGRAM_B = 8'h10;
	localparam logic [7:0] CMD_PAGE_PROGRAM = 8'he8;
	localparam logic [7:0] CMD_OTP_PROGRAM = 8'hc0;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int T_CYCLE_NS = 25;
	localparam int T_WE_SETUP_NS = 20;
	localparam int T_WE_PULSE_NS = 50;
	localparam int T_WE_HOLD_NS = 10;
	localparam int T_READ_ACC_NS = 70;
	localparam int T_RST_PULSE_NS = 100;
	localparam int T_RST_RECOV_NS = 150;
	localparam logic [7:0] WE_SETUP_CYC = 8'((T_WE_SETUP_NS + T_CYCLE_NS - 1) / T_CYCLE_NS);
	localparam logic [7:0] WE_PULSE_CYC = 8'((T_WE_PULSE_NS + T_CYCLE_NS - 1) / T_CYCLE_NS);
	localparam logic [7:0] WE_HOLD_CYC = 8'((T_WE_HOLD_NS + T_CYCLE_NS - 1) / T_CYCLE_NS);
	localparam logic [7:0] READ_ACC_CYC = 8'((T_READ_ACC_NS + T_CYCLE_NS - 1) / T_CYCLE_NS);
	localparam logic [7:0] RST_PULSE_CYC = 8'((T_RST_PULSE_NS + T_CYCLE_NS - 1) / T_CYCLE_NS);
	localparam logic [7:0] RST_RECOV_CYC = 8'((T_RST_RECOV_NS + T_CYCLE_NS - 1) / T_CYCLE_NS);

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef enum logic [2:0] {
		ST_RST_LOW,
		ST_RST_RECOV,
		ST_IDLE,
		ST_W_SETUP,
		ST_W_PULSE,
		ST_W_HOLD,
		ST_R_ACCESS
	} pfi_state_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic rst_n;
		logic protect_accel_pin;
		logic [ADDR_W-1:0] word_address_lines;
		logic [DATA_W-1:0] data_lines_out;
		logic data_lines_oe;
	} pfi_pins_t;

	typedef struct packed {
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pfi_req_t;

	typedef struct packed {
		logic [BLK_W-1:0] block;
		logic [1:0] plane;
		logic param;
	} pfi_blk_t;
endpackage : pfi_pkg

// File: core/pfi_block_map.sv
// Word address to block, plane and parameter-region decoder.
`timescale 1ns/100ps
module pfi_block_map (
	input wire logic [pfi_pkg::ADDR_W-1:0] addr_i,
	output pfi_pkg::pfi_blk_t blk_o
);
	import pfi_pkg::*;

	// ==========================================================================
	// Decode
	// ==========================================================================
	// Eight small blocks sit at the bottom; every other block is a large one.
	function automatic pfi_blk_t decode(input logic [ADDR_W-1:0] a);
		pfi_blk_t b;
		b.plane = a[ADDR_W-1:PLANE_LSB];
		b.param = (a[ADDR_W-1:MAIN_LSB] == '0);
		if (b.param) begin
			b.block = BLK_W'(a[MAIN_LSB-1:PARAM_LSB]);
		end else begin
			b.block = MAIN_BASE_BLK + BLK_W'(a[ADDR_W-1:MAIN_LSB]);
		end
		return b;
	endfunction : decode

	assign blk_o = decode(addr_i);
endmodule : pfi_block_map

// File: sim/pfi_host_monitor.sv
// Concurrent checks on the ports of the flash host controller.
`timescale 1ns/100ps
module pfi_host_monitor (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic req_i,
	input pfi_pkg::pfi_req_t req_data_i,
	input wire logic protect_i,
	input wire logic [pfi_pkg::DATA_W-1:0] data_lines_i,
	input wire logic ready_o,
	input wire logic ack_o,
	input wire logic refused_o,
	input wire logic [pfi_pkg::DATA_W-1:0] rdata_o,
	input pfi_pkg::pfi_pins_t pins_o
);
	import pfi_pkg::*;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);
	logic take;
	assign take = req_i && ready_o;
	a_gate_strobe_clash: assert property (pins_o.oe_n || pins_o.we_n)
		else $error("gate and strobe low together");
	a_ready_after_rst: assert property (ready_o |-> pins_o.rst_n)
		else $error("ready while reset pin low");
	a_standby_idle: assert property (ready_o |-> pins_o.ce_n && !pins_o.data_lines_oe)
		else $error("selected while idle");
	a_dq_in_write: assert property (pins_o.data_lines_oe |-> !pins_o.ce_n && pins_o.oe_n)
		else $error("data driven outside a write");
	a_strobe_walk: assert property ($fell(pins_o.we_n) |-> (!pins_o.we_n)[*2]
		##1 (pins_o.we_n && !pins_o.ce_n) ##1 pins_o.ce_n) else $error("write strobe shape");
	a_addr_hold: assert property (!pins_o.ce_n && !$past(pins_o.ce_n) |->
		$stable(pins_o.word_address_lines) && $stable(pins_o.data_lines_out))
		else $error("address or data moved while selected");
	a_read_walk: assert property (take && !req_data_i.wr |=> !pins_o.oe_n
		&& pins_o.word_address_lines == $past(req_data_i.addr) ##3 ack_o)
		else $error("read cycle shape");
	a_read_capture: assert property (ack_o && !$past(pins_o.oe_n) |->
		rdata_o == $past(data_lines_i)) else $error("read data not captured");
	a_refuse_fast: assert property (refused_o |-> ack_o && $past(take && req_data_i.wr))
		else $error("refusal out of place");
	a_protect_copy: assert property (pins_o.protect_accel_pin == $past(protect_i))
		else $error("protect pin not copied");
	c_write: cover property (take && req_data_i.wr ##5 ack_o);
	c_read: cover property (take && !req_data_i.wr ##4 ack_o);
	c_refuse: cover property (refused_o);
endmodule : pfi_host_monitor

bind pfi_host pfi_host_monitor i_mon (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
	.req_data_i(req_data_i), .protect_i(protect_i), .data_lines_i(data_lines_i),
	.ready_o(ready_o), .ack_o(ack_o), .refused_o(refused_o), .rdata_o(rdata_o), .pins_o(pins_o));

// File: sim/pfi_flash_model.sv
// Behavioural flash device as seen through its pins.
`timescale 1ns/100ps
module pfi_flash_model (
	input pfi_pkg::pfi_pins_t pins_i,
	output logic [pfi_pkg::DATA_W-1:0] dq_o,
	output logic busy_o = 1'b0
);
	import pfi_pkg::*;
	localparam int BUSY_NS = 500;
	localparam int N_BLK = 128;
	logic pend = 1'b0;
	logic [3:0] stat = 4'h0;
	logic [N_BLK-1:0] locked = '0;
	logic wrote = 1'b0;
	logic [7:0] opc = 8'h00;
	logic [ADDR_W-1:0] w_addr = '0;
	logic [DATA_W-1:0] w_data = '0;
	logic [DATA_W-1:0] last = '0;
	logic [DATA_W-1:0] rdv;
	logic [1:0] plane;
	logic all_stat;
	logic drive;
	// Block number of a word address: eight small blocks, then large ones from block 8.
	function automatic int blk_of(input logic [ADDR_W-1:0] a);
		if (a[ADDR_W-1:MAIN_LSB] == '0) begin
			return int'(a[MAIN_LSB-1:PARAM_LSB]);
		end
		return 7 + int'(a[ADDR_W-1:MAIN_LSB]);
	endfunction : blk_of
	assign plane = pins_i.word_address_lines[ADDR_W-1:PLANE_LSB];
	// A running chip erase leaves only status visible in every partition.
	assign all_stat = busy_o && opc == 8'h30;
	assign drive = pins_i.rst_n && !pins_i.ce_n && !pins_i.oe_n && pins_i.we_n;
	assign rdv = (stat[plane] || all_stat) ? {8'h00, !busy_o, 7'h00} :
		(wrote && pins_i.word_address_lines == w_addr) ? w_data :
		pins_i.word_address_lines[15:0] ^ 16'h5a5a;
	// A released bus shows the inverse of the last word so stale data cannot pass.
	assign dq_o = drive ? rdv : ~last;
	always @(negedge drive) last = rdv;
	always @(posedge pins_i.we_n or posedge pins_i.ce_n) begin
		if (pins_i.rst_n && !(pins_i.we_n && pins_i.ce_n)) begin
			if (pend) begin
				pend = 1'b0;
				if (opc == 8'h60) begin
					locked[blk_of(pins_i.word_address_lines)] = pins_i.data_lines_out[7:0] == 8'h01;
				end else if (!locked[blk_of(pins_i.word_address_lines)]) begin
					if (opc inside {8'h40, 8'h10}) begin
						w_addr = pins_i.word_address_lines;
						w_data = pins_i.data_lines_out;
						wrote = 1'b1;
					end
					busy_o = (opc inside {8'h40, 8'h10}) || pins_i.data_lines_out[7:0] == 8'hd0;
				end
			end else begin
				opc = pins_i.data_lines_out[7:0];
				pend = opc inside {8'h40, 8'h10, 8'h20, 8'h30, 8'h60};
				if (opc == 8'h70) begin
					stat[plane] = 1'b1;
				end else if (opc == 8'hff) begin
					stat[plane] = 1'b0;
				end
			end
		end
	end
	always @(posedge busy_o) begin
		#BUSY_NS;
		busy_o = 1'b0;
	end
	always @(negedge pins_i.rst_n) begin
		busy_o = 1'b0;
		pend = 1'b0;
		stat = 4'h0;
	end
endmodule : pfi_flash_model

// File: sim/pfi_host_bench.sv
// Self-checking testbench of the flash host controller against the device model.
`timescale 1ns/100ps
module pfi_host_bench;
	import pfi_pkg::*;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic req_i = 1'b0;
	pfi_req_t req_data_i = '0;
	logic protect_i = 1'b0;
	logic [DATA_W-1:0] data_lines_i, rdata_o, dev_dq, d;
	logic ready_busy_n_i, ready_o, ack_o, refused_o, op_pending_o, dev_busy, r;
	pfi_pins_t pins_o;
	int fail_count = 0;
	int n_tests = 0;
	always #12.5 mclk_i = ~mclk_i;
	assign data_lines_i = pins_o.data_lines_oe ? pins_o.data_lines_out : dev_dq;
	assign ready_busy_n_i = dev_busy ? 1'b0 : 1'b1;
	pfi_host i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
		.req_data_i(req_data_i), .protect_i(protect_i), .data_lines_i(data_lines_i),
		.ready_busy_n_i(ready_busy_n_i), .ready_o(ready_o), .ack_o(ack_o), .refused_o(refused_o),
		.rdata_o(rdata_o), .op_pending_o(op_pending_o), .pins_o(pins_o));
	pfi_flash_model i_flash (.pins_i(pins_o), .dq_o(dev_dq), .busy_o(dev_busy));
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (!ok) begin
			fail_count++;
			$display("Error %0t %s", $time, m);
		end
	endtask : chk
	task automatic end_sim;
		if (fail_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task automatic tick;
		@(posedge mclk_i);
		#2;
	endtask : tick
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		int n = 0;
		tick;
		while (ready_o !== 1'b1 && n++ < 100)
			tick;
		req_i = 1'b1;
		req_data_i = {wr, a, v};
		tick;
		req_i = 1'b0;
		n = 0;
		while (ack_o !== 1'b1 && n++ < 20)
			tick;
		chk(ack_o === 1'b1, "no answer");
		r = refused_o;
		d = rdata_o;
	endtask : xfer
	task automatic wait_idle;
		int n = 0;
		while (op_pending_o !== 1'b0 && n++ < 300)
			tick;
		chk(op_pending_o === 1'b0, "operation never finished");
	endtask : wait_idle
	task automatic t_reset_mode;
		chk(pins_o.rst_n === 1'b0, "reset pin released early");
		xfer(1'b0, 21'h000010, 16'h0000);
		chk(d === 16'h5a4a, "array read after reset");
		xfer(1'b1, 21'h000010, 16'h0070);
		xfer(1'b0, 21'h000010, 16'h0000);
		chk(d === 16'h0080, "status read");
		xfer(1'b0, 21'h080010, 16'h0000);
		chk(d === 16'h5a4a, "status shown in another partition");
		sys_rst_i = 1'b1;
		tick;
		sys_rst_i = 1'b0;
		xfer(1'b0, 21'h000020, 16'h0000);
		chk(d === 16'h5a7a, "array mode after mid-run reset");
	endtask : t_reset_mode
	task automatic t_program;
		logic [7:0] c [2] = '{8'h40, 8'h10};
		for (int i = 0; i < 2; i++) begin
			xfer(1'b1, 21'h000100 + 21'(i), {8'h00, c[i]});
			xfer(1'b1, 21'h000100 + 21'(i), 16'hc3a0 + 16'(i));
			tick;
			chk(r === 1'b0 && op_pending_o === 1'b1, "program not started");
			xfer(1'b1, 21'h008000, 16'h0020);
			chk(r === 1'b1, "second start taken while busy");
			xfer(1'b0, 21'h100000 + 21'(i), 16'h0000);
			chk(d === (16'h5a5a ^ 16'(i)) && ready_busy_n_i === 1'b0, "read beside program");
			wait_idle;
			xfer(1'b0, 21'h000100 + 21'(i), 16'h0000);
			chk(d === 16'hc3a0 + 16'(i), "programmed word");
		end
	endtask : t_program
	task automatic t_pair;
		logic [ADDR_W-1:0] t [3][3] = '{'{21'h001000, 21'h002000, 21'h001fff},
			'{21'h000000, 21'h001000, 21'h000fff}, '{21'h1f8000, 21'h1f0000, 21'h1fffff}};
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, t[i][0], 16'h0020);
			xfer(1'b1, t[i][1], 16'h00d0);
			chk(r === 1'b1, "confirm in other block taken");
			xfer(1'b1, t[i][2], 16'h00d0);
			chk(r === 1'b0 && ready_busy_n_i === 1'b0, "erase not started");
			wait_idle;
		end
	endtask : t_pair
	task automatic t_guard;
		xfer(1'b1, 21'h002000, 16'h0030);
		xfer(1'b1, 21'h002000, 16'h00d0);
		chk(r === 1'b0 && op_pending_o === 1'b1, "chip erase not started");
		xfer(1'b0, 21'h180000, 16'h0000);
		chk(d === 16'h0000, "array shown during chip erase");
		wait_idle;
		xfer(1'b1, 21'h002000, 16'h0060);
		xfer(1'b1, 21'h002000, 16'h0001);
		chk(r === 1'b0 && op_pending_o === 1'b0, "lock confirm started work");
		xfer(1'b1, 21'h002000, 16'h0020);
		xfer(1'b1, 21'h002abc, 16'h00d0);
		chk(ready_busy_n_i === 1'b1 && op_pending_o === 1'b1, "locked block erased");
		xfer(1'b1, 21'h0e0000, 16'h00e8);
		chk(r === 1'b1, "page program taken while pending");
		xfer(1'b1, 21'h000080, 16'h00c0);
		chk(r === 1'b1, "otp program taken while pending");
		sys_rst_i = 1'b1;
		tick;
		chk(op_pending_o === 1'b0 && pins_o.rst_n === 1'b0, "reset kept pending");
		sys_rst_i = 1'b0;
	endtask : t_guard
	initial begin
		repeat (5) @(posedge mclk_i);
		#2;
		sys_rst_i = 1'b0;
		t_reset_mode;
		t_program;
		t_pair;
		t_guard;
		protect_i = 1'b1;
		tick;
		tick;
		chk(pins_o.protect_accel_pin === 1'b1, "protect pin not driven");
		end_sim;
	end
	initial begin
		#200000;
		fail_count++;
		end_sim;
	end
endmodule : pfi_host_bench
